//--- hw/umsrc_pkg.sv
// Behaviour
// [RQ1] carrier-detect change since last status read sets its flag; interrupt when enabled.
// [RQ2] ring flag sets only on ring input low-to-high; interrupt when enabled.
// [RQ3] data-set-ready change since last status read sets its flag; interrupt when enabled.
// [RQ4] clear-to-send change since last status read sets its flag; interrupt when enabled.
// [RQ5] rs-485 direction drops after 0..15 bit times following the last stop bit.
// [RQ6] turn-around delay field is writable only while enhanced write enable is set.
// [RQ7] transmitter disable halts the shift register; queued and new bytes stay unsent.
// [RQ8] clearing transmitter disable resumes sending the queued bytes.
// [RQ9] send-immediate works only while the transmitter is enabled.
// [RQ10] receiver disable finishes a character in progress, then accepts no more.
// [RQ11] clearing receiver disable on an idle line receives the next character normally.
// [RQ12] receive fifo stays readable whether or not the receiver is disabled.
// [RQ13] tx disabled: mode 0 sends only a pending flow character, mode 1 keeps sending.
// [RQ14] rx disabled: mode 0 ignores everything, mode 1 still acts on flow characters.
// [RQ15] eight-bit read/write scratch register, all ones after reset.
// [RQ16] two bits pick a trigger table; tables 0..2 trip auto flow one level off.
// [RQ17] rs-485 direction control overrides automatic request-to-send flow control.
// [RQ18] modem control select bit picks rts or dtr pin as direction output.
// [RQ19] direction high when a byte loads, low after last stop bit leaves.
// [RQ20] tx interrupt on holding empty, or on shift register empty in rs-485 mode.
// [RQ21] flow character sent with empty tx fifo leaves the direction output unchanged.
// [RQ22] polarity bit selects active-high or inverted infrared receive data.
// [RQ23] enhanced write enable must be set to change write-side modem bits.
// [RQ24] status read clears all four change flags; interrupt drops when none remain.
package umsrc_pkg;

    // word-aligned byte offsets on the bus
    localparam logic [7:0] OFF_MODEM = 8'h00;
    localparam logic [7:0] OFF_SCRATCH = 8'h04;
    localparam logic [7:0] OFF_FEATURE = 8'h08;
    localparam logic [7:0] OFF_IER = 8'h0C;
    localparam logic [7:0] OFF_EFR = 8'h10;
    localparam logic [7:0] OFF_MCR = 8'h14;
    localparam logic [7:0] OFF_LINE_STATE = 8'h18;

    // line_direction_control fields
    localparam int LDC_DELAY_LSB = 4;
    localparam int LDC_TX_DIS = 3;
    localparam int LDC_RX_DIS = 2;
    localparam int LDC_TX_MODE = 1;
    localparam int LDC_RX_MODE = 0;
    // feature_control fields
    localparam int FCR_TABLE_LSB = 6;
    localparam int FCR_RS485 = 5;
    localparam int FCR_IR_INV = 4;
    localparam logic [1:0] TABLE_D = 2'h3;
    // other field positions
    localparam int IER_TX = 1;
    localparam int IER_MODEM = 3;
    localparam int EFR_WR_EN = 4;
    localparam int EFR_AUTO_RTS = 6;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_SEL_DTR = 2;
    localparam int MCR_SEND_NOW = 3;
    // synchroniser bit order
    localparam int PIN_CTS = 0;
    localparam int PIN_DSR = 1;
    localparam int PIN_RI = 2;
    localparam int PIN_CD = 3;
    localparam int PIN_IR = 4;

    localparam logic [7:0] SCRATCH_RST = 8'hFF;
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam logic [4:0] PINS_IDLE = 5'h1F;

    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_SEND = 3'b010,
        DIR_HOLD = 3'b100
    } umsrc_dir_t;

    typedef struct packed {
        logic fifo_empty;
        logic tsr_empty;
        logic data_load;
        logic stop_done;
        logic bit_tick;
        logic flow_pending;
    } umsrc_tx_t;

    typedef struct packed {
        logic busy;
        logic above_next;
        logic below_next;
        logic above_hyst;
        logic below_hyst;
    } umsrc_rx_t;

    typedef struct packed {
        logic tx_run;
        logic tx_flow_ok;
        logic send_now;
        logic rx_take_data;
        logic rx_take_flow;
        logic ir_rx_data;
        logic [1:0] trig_table;
        logic [3:0] hyst_sel;
        logic dir_active;
    } umsrc_ctl_t;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [3:0] last;
        logic [3:0] delta;
        logic [7:0] ldc;
        logic [7:0] scratch;
        logic [7:0] feature_control;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] modem_control_reg;
        umsrc_dir_t dir;
        logic [3:0] dcnt;
        logic flow_off;
        logic flow_grace;
        logic rx_grace;
        logic ack;
        logic [7:0] dat;
        logic rts_n;
        logic dtr_n;
        logic msi_irq;
        logic tx_irq;
        umsrc_ctl_t ctl;
    } umsrc_state_t;

endpackage

//--- hw/umsrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module umsrc_top import umsrc_pkg::*; (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic carrier_detect_n,
    input wire logic ring_indicator_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire logic ir_rx,
    output logic rts_n,
    output logic dtr_n,
    input wire umsrc_tx_t tx_stat,
    input wire umsrc_rx_t rx_stat,
    output umsrc_ctl_t ctl,
    output logic msi_irq,
    output logic tx_irq
);

    localparam umsrc_state_t STATE_RST = '{
        sync1: PINS_IDLE,
        sync2: PINS_IDLE,
        last: PINS_IDLE[3:0],
        delta: 4'h0,
        ldc: REG_ZERO,
        scratch: SCRATCH_RST,
        feature_control: REG_ZERO,
        interrupt_enable_reg: REG_ZERO,
        enhanced_feature_reg: REG_ZERO,
        modem_control_reg: REG_ZERO,
        dir: DIR_IDLE,
        dcnt: 4'h0,
        flow_off: 1'b0,
        flow_grace: 1'b0,
        rx_grace: 1'b0,
        ack: 1'b0,
        dat: REG_ZERO,
        rts_n: 1'b1,
        dtr_n: 1'b1,
        msi_irq: 1'b0,
        tx_irq: 1'b0,
        ctl: '0
    };

    umsrc_state_t s_reg;
    umsrc_state_t s_next;

    // bus decode; ack is registered so every access answers in one cycle
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] word_off;
    assign bus_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    assign bus_rd = bus_req & ~wb_we_i;
    assign word_off = {wb_adr_i[7:2], 2'b00};

    // modem change events from the synchronised pins
    logic [3:0] pin_event;
    assign pin_event[PIN_CTS] = s_reg.sync2[PIN_CTS] ^ s_reg.last[PIN_CTS]; // RQ4
    assign pin_event[PIN_DSR] = s_reg.sync2[PIN_DSR] ^ s_reg.last[PIN_DSR]; // RQ3
    assign pin_event[PIN_CD] = s_reg.sync2[PIN_CD] ^ s_reg.last[PIN_CD]; // RQ1
    // only the end of ringing counts, pin going back high
    assign pin_event[PIN_RI] = s_reg.sync2[PIN_RI] & ~s_reg.last[PIN_RI]; // RQ2

    logic status_read;
    assign status_read = bus_rd & (word_off == OFF_MODEM);

    logic tx_dis;
    logic rx_dis;
    logic rs485_on;
    logic sel_dtr;
    logic auto_rts;
    logic flow_above;
    logic flow_below;
    assign tx_dis = s_reg.ldc[LDC_TX_DIS];
    assign rx_dis = s_reg.ldc[LDC_RX_DIS];
    assign rs485_on = s_reg.feature_control[FCR_RS485];
    assign sel_dtr = s_reg.modem_control_reg[MCR_SEL_DTR];
    assign auto_rts = s_reg.enhanced_feature_reg[EFR_AUTO_RTS];
    // tables 0..2 use the next trigger level, table D the hysteresis field
    assign flow_above = (s_reg.feature_control[7:FCR_TABLE_LSB] == TABLE_D) ?
        rx_stat.above_hyst : rx_stat.above_next; // RQ16
    assign flow_below = (s_reg.feature_control[7:FCR_TABLE_LSB] == TABLE_D) ?
        rx_stat.below_hyst : rx_stat.below_next; // RQ16

    logic [7:0] rd_data;
    always_comb begin
        unique case (word_off)
            OFF_MODEM: rd_data = {~s_reg.sync2[3:0], s_reg.delta};
            OFF_SCRATCH: rd_data = s_reg.scratch;
            OFF_FEATURE: rd_data = s_reg.feature_control;
            OFF_IER: rd_data = s_reg.interrupt_enable_reg;
            OFF_EFR: rd_data = s_reg.enhanced_feature_reg;
            OFF_MCR: rd_data = s_reg.modem_control_reg;
            OFF_LINE_STATE: rd_data = {s_reg.ctl.dir_active, s_reg.rx_grace,
                s_reg.flow_grace, s_reg.flow_off, s_reg.dcnt};
            default: rd_data = REG_ZERO;
        endcase
    end

    always_comb begin
        s_next = s_reg;

        // two-stage synchroniser; only sync2 feeds logic
        s_next.sync1 = {ir_rx, carrier_detect_n, ring_indicator_n, dsr_n,
            cts_n};
        s_next.sync2 = s_reg.sync1;
        s_next.last = s_reg.sync2[3:0];

        // a change landing on the clearing read still sets its flag
        s_next.delta = (status_read ? 4'h0 : s_reg.delta) | pin_event; // RQ24
        s_next.msi_irq = s_reg.interrupt_enable_reg[IER_MODEM] & (|s_next.delta); // RQ1

        s_next.ack = bus_req;
        s_next.dat = bus_rd ? rd_data : REG_ZERO;
        s_next.ctl.send_now = 1'b0;

        if (bus_wr) begin
            unique case (word_off)
                OFF_MODEM: begin
                    // whole write side latched only under enhanced enable
                    if (s_reg.enhanced_feature_reg[EFR_WR_EN]) begin // RQ6 RQ23
                        s_next.ldc = wb_dat_i[7:0];
                    end
                end
                OFF_SCRATCH: s_next.scratch = wb_dat_i[7:0]; // RQ15
                OFF_FEATURE: s_next.feature_control = wb_dat_i[7:0];
                OFF_IER: s_next.interrupt_enable_reg = wb_dat_i[7:0];
                OFF_EFR: s_next.enhanced_feature_reg = wb_dat_i[7:0];
                OFF_MCR: begin
                    // send-now is self clearing, never stored
                    s_next.modem_control_reg = {wb_dat_i[7:4], 1'b0, wb_dat_i[2:0]};
                    s_next.ctl.send_now = wb_dat_i[MCR_SEND_NOW] &
                        ~tx_dis; // RQ9
                end
                default: ;
            endcase
        end

        // transmit side gating
        s_next.ctl.tx_run = ~tx_dis; // RQ7 RQ8
        // a flow char pending before the disable may still go out
        s_next.flow_grace = tx_stat.flow_pending &
            (s_reg.flow_grace | ~tx_dis); // RQ13
        s_next.ctl.tx_flow_ok = ~tx_dis | s_reg.ldc[LDC_TX_MODE] |
            s_next.flow_grace; // RQ13

        // receive side: a character under way when disabled is finished
        s_next.rx_grace = rx_stat.busy & (s_reg.rx_grace | ~rx_dis); // RQ10
        // re-enable takes effect at once; mid-character may load junk
        s_next.ctl.rx_take_data = ~rx_dis | s_next.rx_grace; // RQ10 RQ11
        s_next.ctl.rx_take_flow = s_next.ctl.rx_take_data |
            s_reg.ldc[LDC_RX_MODE]; // RQ14

        s_next.ctl.ir_rx_data = s_reg.sync2[PIN_IR] ^
            s_reg.feature_control[FCR_IR_INV]; // RQ22
        s_next.ctl.trig_table = s_reg.feature_control[7:FCR_TABLE_LSB]; // RQ16
        s_next.ctl.hyst_sel = s_reg.feature_control[3:0];

        // auto flow threshold tracking, set wins over release
        if (flow_above) begin // RQ16
            s_next.flow_off = 1'b1;
        end else if (flow_below) begin
            s_next.flow_off = 1'b0;
        end

        // rs-485 direction; flow-char loads are not data_load
        unique case (s_reg.dir)
            DIR_IDLE: begin
                if (rs485_on && tx_stat.data_load) begin // RQ19 RQ21
                    s_next.dir = DIR_SEND;
                end
            end
            DIR_SEND: begin
                if (!rs485_on) begin
                    s_next.dir = DIR_IDLE;
                end else if (tx_stat.stop_done && tx_stat.fifo_empty &&
                        !tx_stat.data_load) begin // RQ19
                    if (s_reg.ldc[7:LDC_DELAY_LSB] == 4'h0) begin // RQ5
                        s_next.dir = DIR_IDLE;
                    end else begin
                        s_next.dir = DIR_HOLD;
                        s_next.dcnt = s_reg.ldc[7:LDC_DELAY_LSB]; // RQ5
                    end
                end
            end
            DIR_HOLD: begin
                if (!rs485_on) begin
                    s_next.dir = DIR_IDLE;
                end else if (tx_stat.data_load) begin
                    s_next.dir = DIR_SEND;
                end else if (tx_stat.bit_tick) begin
                    s_next.dcnt = s_reg.dcnt - 4'h1; // RQ5
                    if (s_reg.dcnt == 4'h1) begin
                        s_next.dir = DIR_IDLE;
                    end
                end
            end
            default: s_next.dir = DIR_IDLE;
        endcase
        if (s_next.dir == DIR_IDLE) begin
            s_next.dcnt = 4'h0;
        end
        s_next.ctl.dir_active = (s_next.dir != DIR_IDLE);

        // pin drive: rs-485 owns the selected pin, auto flow is ignored
        if (s_reg.feature_control[FCR_RS485]) begin // RQ17
            if (sel_dtr) begin // RQ18
                s_next.dtr_n = s_next.ctl.dir_active;
                s_next.rts_n = ~s_reg.modem_control_reg[MCR_RTS];
            end else begin
                s_next.rts_n = s_next.ctl.dir_active;
                s_next.dtr_n = ~s_reg.modem_control_reg[MCR_DTR];
            end
        end else begin
            s_next.rts_n = ~s_reg.modem_control_reg[MCR_RTS] |
                (auto_rts & ~sel_dtr & s_next.flow_off);
            s_next.dtr_n = ~s_reg.modem_control_reg[MCR_DTR] |
                (auto_rts & sel_dtr & s_next.flow_off);
        end

        // rs-485 waits for the shift register too, so the line is idle
        s_next.tx_irq = s_reg.interrupt_enable_reg[IER_TX] & tx_stat.fifo_empty &
            (~rs485_on | tx_stat.tsr_empty); // RQ20
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // receive fifo reads bypass this block entirely // RQ12
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = {24'h000000, s_reg.dat};
    assign rts_n = s_reg.rts_n;
    assign dtr_n = s_reg.dtr_n;
    assign ctl = s_reg.ctl;
    assign msi_irq = s_reg.msi_irq;
    assign tx_irq = s_reg.tx_irq;

endmodule // umsrc_top
`default_nettype wire

//--- tb/umsrc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module umsrc_chk import umsrc_pkg::*; (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire umsrc_tx_t tx_stat,
    input wire umsrc_ctl_t ctl,
    input wire logic msi_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence dir_up;
        $rose(ctl.dir_active);
    endsequence
    ack_late_a: assert property (bus_req |=> wb_ack_o)
        else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    dat_byte_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    msi_clear_a: assert property ($fell(msi_irq)
        |-> wb_ack_o || $past(wb_ack_o)) else $error("msi dropped unasked");
    dir_load_a: assert property (dir_up |-> $past(tx_stat.data_load))
        else $error("direction raised without a load");
    dir_pin_a: assert property (dir_up |-> rts_n || dtr_n)
        else $error("direction pin not high");
    send_once_a: assert property (ctl.send_now |=> !ctl.send_now)
        else $error("send pulse too long");
    send_run_a: assert property (ctl.send_now |-> ctl.tx_run)
        else $error("send while transmitter halted");
endmodule // umsrc_chk
bind umsrc_top umsrc_chk u_chk (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .rts_n, .dtr_n, .tx_stat, .ctl, .msi_irq);
`default_nettype wire

//--- tb/umsrc_far.sv
`timescale 1ns/1ps
`default_nettype none
module umsrc_far import umsrc_pkg::*; (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic send,
    input wire logic flow,
    output var umsrc_tx_t tx_stat
);
    // bit clock runs free like a baud divider; stop never meets a tick
    logic [1:0] div_reg;
    logic [3:0] bits_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_reg <= 2'h0;
            bits_reg <= 4'h0;
            tx_stat <= 6'h30;
        end else begin
            div_reg <= div_reg + 2'h1;
            tx_stat.bit_tick <= div_reg == 2'h3;
            tx_stat.data_load <= send;
            tx_stat.fifo_empty <= !send;
            tx_stat.stop_done <= 1'b0;
            // xon/xoff waiting in the transmitter, no data byte involved
            tx_stat.flow_pending <= flow;
            if (send) begin
                bits_reg <= 4'hA;
                tx_stat.tsr_empty <= 1'b0;
            end else if (div_reg == 2'h3 && bits_reg > 4'h1) begin
                bits_reg <= bits_reg - 4'h1;
            end else if (div_reg == 2'h1 && bits_reg == 4'h1) begin
                bits_reg <= 4'h0;
                tx_stat.stop_done <= 1'b1;
                tx_stat.tsr_empty <= 1'b1;
            end
        end
    end
endmodule // umsrc_far
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import umsrc_pkg::*;;
    logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, send, flow;
    logic carrier_detect_n, ring_indicator_n, dsr_n, cts_n, ir_rx;
    logic rts_n, dtr_n, msi_irq, tx_irq;
    logic [3:0] wb_sel_i;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    umsrc_tx_t tx_stat;
    umsrc_rx_t rx_stat;
    umsrc_ctl_t ctl;
    int errors, checks, sends, n;
    umsrc_top dut (
        .sys_clk(sys_clk),
        .srst(srst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .carrier_detect_n(carrier_detect_n),
        .ring_indicator_n(ring_indicator_n),
        .dsr_n(dsr_n),
        .cts_n(cts_n),
        .ir_rx(ir_rx),
        .rts_n(rts_n),
        .dtr_n(dtr_n),
        .tx_stat(tx_stat),
        .rx_stat(rx_stat),
        .ctl(ctl),
        .msi_irq(msi_irq),
        .tx_irq(tx_irq)
    );
    umsrc_far far (
        .sys_clk(sys_clk),
        .srst(srst),
        .send(send),
        .flow(flow),
        .tx_stat(tx_stat)
    );
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (ctl.send_now === 1'b1) sends++;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cb(input string s, input logic e, g);
        chk(s, {7'h0, e}, {7'h0, g});
    endtask
    task automatic stall(input logic ok);
        if (!ok) begin
            errors++;
            test_done();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d,
            output logic [7:0] q);
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        stall(n < 40);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string s, input logic [7:0] a, e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(s, e, q);
    endtask
    // waits for a stop (1) or a bit tick (0) from the line side
    task automatic wait_ev(input logic stop);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((stop ? tx_stat.stop_done : tx_stat.bit_tick) !== 1'b1
            && n < 80);
        stall(n < 80);
    endtask
    initial begin
        srst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, send, flow} = 5'h00;
        wb_sel_i = 4'h1;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        rx_stat = '0;
        {carrier_detect_n, ring_indicator_n, dsr_n, cts_n, ir_rx} = 5'h1F;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd("scratch_rst", OFF_SCRATCH, SCRATCH_RST);
        wr(OFF_SCRATCH, 8'h5A);
        rd("scratch", OFF_SCRATCH, 8'h5A);
        rd("unmapped", 8'hFC, 8'h00);
        {cts_n, dsr_n, carrier_detect_n, ring_indicator_n} <= 4'h0;
        repeat (6) @(posedge sys_clk);
        cb("msi_masked", 1'b0, msi_irq);
        wr(OFF_IER, 8'h0A);
        cb("msi_on", 1'b1, msi_irq);
        rd("deltas", OFF_MODEM, 8'hFB);
        cb("msi_off", 1'b0, msi_irq);
        rd("cleared", OFF_MODEM, 8'hF0);
        ring_indicator_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd("ring_end", OFF_MODEM, 8'hB4);
        ir_rx <= 1'b0;
        repeat (5) @(posedge sys_clk);
        cb("ir_plain", 1'b0, ctl.ir_rx_data);
        wr(OFF_FEATURE, 8'h10);
        cb("ir_inv", 1'b1, ctl.ir_rx_data);
        for (int t = 0; t < 4; t++) begin
            wr(OFF_FEATURE, {t[1:0], 6'h00});
            chk("table", {6'h0, t[1:0]}, {6'h0, ctl.trig_table});
        end
        wr(OFF_MODEM, 8'h08);
        cb("gated", 1'b1, ctl.tx_run);
        wr(OFF_EFR, 8'h10);
        wr(OFF_MODEM, 8'h08);
        cb("tx_halt", 1'b0, ctl.tx_run);
        cb("flow_halt", 1'b0, ctl.tx_flow_ok);
        wr(OFF_MCR, 8'h08);
        wr(OFF_MODEM, 8'h0A);
        cb("flow_keep", 1'b1, ctl.tx_flow_ok);
        chk("now_blocked", 8'h00, sends[7:0]);
        wr(OFF_MODEM, 8'h00);
        cb("tx_resume", 1'b1, ctl.tx_run);
        wr(OFF_MCR, 8'h08);
        repeat (2) @(posedge sys_clk);
        chk("now_sent", 8'h01, sends[7:0]);
        rx_stat.busy <= 1'b1;
        wr(OFF_MODEM, 8'h04);
        cb("rx_finish", 1'b1, ctl.rx_take_data);
        rx_stat.busy <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cb("rx_stop", 1'b0, ctl.rx_take_data);
        cb("rx_flow_off", 1'b0, ctl.rx_take_flow);
        wr(OFF_MODEM, 8'h05);
        cb("rx_flow_on", 1'b1, ctl.rx_take_flow);
        wr(OFF_MODEM, 8'h20);
        cb("rx_back", 1'b1, ctl.rx_take_data);
        wr(OFF_FEATURE, 8'h20);
        for (int s = 0; s < 2; s++) begin
            wr(OFF_MCR, s ? 8'h06 : 8'h01);
            send <= 1'b1;
            @(posedge sys_clk);
            send <= 1'b0;
            repeat (2) @(posedge sys_clk);
            cb("dir_up", 1'b1, s ? dtr_n : rts_n);
            cb("pin_free", 1'b0, s ? rts_n : dtr_n);
            cb("irq_busy", 1'b0, tx_irq);
            wait_ev(1'b1);
            wait_ev(1'b0);
            wait_ev(1'b0);
            cb("dir_hold", 1'b1, s ? dtr_n : rts_n);
            repeat (2) @(posedge sys_clk);
            cb("dir_down", 1'b0, s ? dtr_n : rts_n);
            cb("irq_done", 1'b1, tx_irq);
        end
        // flow char with an empty fifo must not turn the line around
        flow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cb("dir_flow", 1'b0, dtr_n);
        wr(OFF_MODEM, 8'h08);
        cb("flow_grace", 1'b1, ctl.tx_flow_ok);
        flow <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cb("flow_done", 1'b0, ctl.tx_flow_ok);
        flow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cb("flow_new", 1'b0, ctl.tx_flow_ok);
        flow <= 1'b0;
        wr(OFF_MODEM, 8'h00);
        wr(OFF_FEATURE, 8'h00);
        // shift register still busy here, holding empty already
        send <= 1'b1;
        @(posedge sys_clk);
        send <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cb("irq_thr", 1'b1, tx_irq);
        wait_ev(1'b1);
        wr(OFF_EFR, 8'h50);
        wr(OFF_MCR, 8'h02);
        cb("rts_low", 1'b0, rts_n);
        rx_stat <= 5'h08; // above next level
        repeat (3) @(posedge sys_clk);
        cb("rts_trip", 1'b1, rts_n);
        rx_stat <= 5'h04; // below next level
        repeat (3) @(posedge sys_clk);
        cb("rts_back", 1'b0, rts_n);
        wr(OFF_FEATURE, 8'hC5);
        chk("hyst", 8'h05, {4'h0, ctl.hyst_sel});
        rx_stat <= 5'h08;
        repeat (3) @(posedge sys_clk);
        cb("next_ignored", 1'b0, rts_n);
        rx_stat <= 5'h0A; // hysteresis level crossed too
        repeat (3) @(posedge sys_clk);
        cb("hyst_trip", 1'b1, rts_n);
        wr(OFF_FEATURE, 8'hE5);
        cb("rs485_wins", 1'b0, rts_n);
        rx_stat <= '0;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
